// ===== core/psapc_pkg.sv
// Purpose: shared constants and types for the strapped amp port
// Assumes: clk_sys at 25 MHz, 16-bit audio words
// Notes: imported by the amp end and the host end
package psapc_pkg;
	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 25_000_000; // system clock rate
	localparam int CLK_MHZ = CLK_HZ / 1_000_000; // same in MHz
	localparam int SD_LEAD_NS = 10_000; // sleep lead before shutdown
	localparam logic [7:0] SD_LEAD_CYC =
		8'((SD_LEAD_NS * CLK_MHZ + 999) / 1000); // rounded up
	localparam int LR_STOP_HZ = 8_000; // frame slower than this: stopped
	localparam logic [11:0] LR_STOP_CYC = 12'(CLK_HZ / LR_STOP_HZ);
	localparam logic [7:0] CLK_STOP_CYC = 8'hFF; // mclk/bclk idle limit
	// ------------------------------------------------------------
	// rate classes
	// ------------------------------------------------------------
	// class i spans bounds i..i+1: 12,16,24,32,38,44.1,48 kHz, high
	localparam int FS_BND_HZ [9] = '{10_000, 14_000, 20_000, 28_000,
		35_000, 41_000, 46_000, 50_000, 100_000};
	localparam logic [2:0] FS_HI = 3'h7; // above 48 kHz
	localparam int MCLK_RATIO [5] = '{128, 192, 256, 384, 512};
	localparam int MCLK_TOL = 2; // edges of slack per frame
	localparam int BCLK_RATIO [3] = '{32, 48, 64};
	localparam int BCLK_TOL = 1;
	// least mclk ratio code per rate class
	localparam logic [2:0] MCLK_MIN_CODE [8] = '{3'h4, 3'h2, 3'h1,
		3'h0, 3'h0, 3'h0, 3'h0, 3'h0};
	localparam int WORD_BITS = 16; // bits kept per channel
	localparam int PWM_SH_LO = 4; // switching at 16 x fs
	localparam int PWM_SH_HI = 3; // switching at 8 x fs
	localparam logic [15:0] SC_LIMIT = 16'h6000; // soft clip magnitude
	localparam logic [1:0] GAIN_REG_MODE = 2'h3;
	// ------------------------------------------------------------
	// host register map
	// ------------------------------------------------------------
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_MDIV = 8'h04;
	localparam logic [7:0] A_BDIV = 8'h08;
	localparam logic [7:0] A_BSEL = 8'h0C;
	localparam logic [7:0] A_LEFT = 8'h10;
	localparam logic [7:0] A_RIGHT = 8'h14;
	localparam logic [7:0] A_STAT = 8'h18;
	localparam logic [7:0] A_IST = 8'h1C;
	localparam logic [7:0] A_IMASK = 8'h20;
	localparam int C_SDN = 0; // shutdown released
	localparam int C_SLEEP = 1;
	localparam int C_FREQ = 2;
	localparam int C_PLOAD = 3;
	localparam int C_GAIN = 4; // two bits
	localparam int C_SCLIP = 6;
	localparam int C_RUN = 7; // clocks running
	localparam logic [7:0] STRAP_MASK = 8'h7C;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] MDIV_RST = 8'h02;
	localparam logic [7:0] BDIV_RST = 8'h04;
	localparam logic [1:0] BSEL_RST = 2'h2;
	localparam int IRQ_FRAME = 0; // new frame started
	localparam int IRQ_FFALL = 1; // fault line fell
	localparam int IRQ_FRISE = 2; // fault line rose
	// amp end states
	typedef enum logic [1:0] {ST_SHUT = 2'b00, ST_WAIT = 2'b01,
		ST_PLAY = 2'b10, ST_SLEEP = 2'b11} psapc_state_t;
	// frame period to {bad, class}
	function automatic logic [3:0] fs_class(input logic [11:0] p);
		int pi;
		logic [3:0] r;
		pi = int'(p);
		r = 4'h8;
		for (int i = 1; i < 9; i++) begin
			if (pi > CLK_HZ / FS_BND_HZ[i] &&
				pi <= CLK_HZ / FS_BND_HZ[i-1]) begin
				r = {1'b0, 3'(i - 1)};
			end
		end
		return r;
	endfunction : fs_class
	// mclk edges per frame to {bad, code}
	function automatic logic [3:0] mclk_class(input logic [9:0] c);
		logic [3:0] r;
		r = 4'h8;
		for (int i = 0; i < 5; i++) begin
			if (int'(c) >= MCLK_RATIO[i] - MCLK_TOL &&
				int'(c) <= MCLK_RATIO[i] + MCLK_TOL) begin
				r = {1'b0, 3'(i)};
			end
		end
		return r;
	endfunction : mclk_class
	// bclk edges per frame to {bad, code}
	function automatic logic [2:0] bclk_class(input logic [6:0] c);
		logic [2:0] r;
		r = 3'h4;
		for (int i = 0; i < 3; i++) begin
			if (int'(c) >= BCLK_RATIO[i] - BCLK_TOL &&
				int'(c) <= BCLK_RATIO[i] + BCLK_TOL) begin
				r = {1'b0, 2'(i)};
			end
		end
		return r;
	endfunction : bclk_class
endpackage : psapc_pkg

// ===== core/psapc_if.sv
// Purpose: pins between the host audio processor and the amp
// Assumes: fault line has a board pull-up
// Notes: open-drain fault resolved here
`timescale 1ns/1ps
`default_nettype none
interface psapc_if;
	logic audio_mclk; // master clock
	logic audio_bclk; // bit clock
	logic audio_lrclk; // frame clock, low = left
	logic audio_sdata; // serial audio data
	logic amp_shutdown_n; // low = shutdown
	logic amp_sleep_or_addr_pin; // high = sleep
	logic switch_rate_select_pin; // high = 8 x fs
	logic parallel_load_select_pin; // high = parallel load
	logic soft_clip_level_pin; // high = soft clipper on
	logic [1:0] gain_sel_pin; // 11 = register control
	logic amp_fault_n_o; // pulled-down level
	logic amp_fault_n_oe; // high while amp pulls line
	wire amp_fault_n; // resolved line
	// pull-up unless the amp drives
	assign amp_fault_n = amp_fault_n_oe ? amp_fault_n_o : 1'b1;
	modport amp (input audio_mclk, audio_bclk, audio_lrclk,
		audio_sdata, amp_shutdown_n, amp_sleep_or_addr_pin,
		switch_rate_select_pin, parallel_load_select_pin,
		soft_clip_level_pin, gain_sel_pin,
		output amp_fault_n_o, amp_fault_n_oe);
	modport host (output audio_mclk, audio_bclk, audio_lrclk,
		audio_sdata, amp_shutdown_n, amp_sleep_or_addr_pin,
		switch_rate_select_pin, parallel_load_select_pin,
		soft_clip_level_pin, gain_sel_pin,
		input amp_fault_n);
endinterface : psapc_if
`default_nettype wire

// ===== core/psapc_amp.sv
// Purpose: amp end, pin control of shutdown, sleep and rates
// Assumes: all pin inputs asynchronous to clk_sys
// Notes: no registers; behaviour comes only from pins
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module psapc_amp
	import psapc_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// pins from the host
	psapc_if.amp pins,
	// board side
	input wire logic supply_ok,
	input wire logic hp_mute_req,
	// output stage
	output logic pwm_l,
	output logic pwm_r,
	output logic pwm_en,
	// status
	output logic hp_mute,
	output logic clk_err,
	output logic reg_mode,
	output logic [2:0] fs_code
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic m_s1, m_s2, m_p; // mclk sync and previous
		logic b_s1, b_s2, b_p; // bclk sync and previous
		logic l_s1, l_s2, l_p; // lrclk sync and previous
		logic d_s1, d_s2; // data sync
		logic sd_s1, sd_s2; // shutdown sync
		logic sl_s1, sl_s2; // sleep sync
		logic fr_s1, fr_s2; // rate select sync
		logic pl_s1, pl_s2; // parallel load sync
		logic sc_s1, sc_s2; // soft clip sync
		logic [1:0] g_s1, g_s2; // gain sync
		logic su_s1, su_s2; // supply sync
		logic mq_s1, mq_s2; // mute request sync
		psapc_state_t state;
		logic freq, pload, sclip, regm; // held straps
		logic [11:0] per; // cycles since frame start
		logic [9:0] mcnt; // mclk edges this frame
		logic [6:0] bcnt; // bclk edges this frame
		logic [7:0] m_idle, b_idle; // cycles since last edge
		logic frame_ok; // last frame clocks valid
		logic [2:0] fsc, mcode; // last good classes
		logic lr_bit; // lrclk at last bclk rise
		logic [5:0] bit_idx; // slot within half frame
		logic [15:0] shreg, samp_l, samp_r;
		logic [5:0] pwm_cnt; // position in PWM period
		logic pwm_l, pwm_r, out_en, fault, hp_mute;
	} psapc_amp_t;
	psapc_amp_t s_r, s_nxt;
	logic m_rise, b_rise, l_fall, clk_bad, wrap; // events
	logic [3:0] fsv, mcv; // frame classes
	logic [2:0] bcv;
	logic [6:0] pwm_per, duty_l, duty_r; // in mclk edges
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// sample to duty in mclk edges, with optional clip
	function automatic logic [6:0] to_duty(input logic [15:0] smp,
		input logic [6:0] per, input logic clip);
		logic [15:0] v;
		logic [22:0] prod;
		v = smp;
		if (clip && !smp[15] && smp > SC_LIMIT) begin
			v = SC_LIMIT;
		end else if (clip && smp[15] && smp < 16'(-SC_LIMIT)) begin
			v = 16'(-SC_LIMIT);
		end
		prod = 23'(v ^ 16'h8000) * 23'(per);
		return prod[22:16];
	endfunction : to_duty
	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		// two-flop synchronisers
		s_nxt.m_s1 = pins.audio_mclk;
		s_nxt.m_s2 = s_r.m_s1;
		s_nxt.m_p = s_r.m_s2;
		s_nxt.b_s1 = pins.audio_bclk;
		s_nxt.b_s2 = s_r.b_s1;
		s_nxt.b_p = s_r.b_s2;
		s_nxt.l_s1 = pins.audio_lrclk;
		s_nxt.l_s2 = s_r.l_s1;
		s_nxt.l_p = s_r.l_s2;
		s_nxt.d_s1 = pins.audio_sdata;
		s_nxt.d_s2 = s_r.d_s1;
		s_nxt.sd_s1 = pins.amp_shutdown_n;
		s_nxt.sd_s2 = s_r.sd_s1;
		s_nxt.sl_s1 = pins.amp_sleep_or_addr_pin;
		s_nxt.sl_s2 = s_r.sl_s1;
		s_nxt.fr_s1 = pins.switch_rate_select_pin;
		s_nxt.fr_s2 = s_r.fr_s1;
		s_nxt.pl_s1 = pins.parallel_load_select_pin;
		s_nxt.pl_s2 = s_r.pl_s1;
		s_nxt.sc_s1 = pins.soft_clip_level_pin;
		s_nxt.sc_s2 = s_r.sc_s1;
		s_nxt.g_s1 = pins.gain_sel_pin;
		s_nxt.g_s2 = s_r.g_s1;
		s_nxt.su_s1 = supply_ok;
		s_nxt.su_s2 = s_r.su_s1;
		s_nxt.mq_s1 = hp_mute_req;
		s_nxt.mq_s2 = s_r.mq_s1;
		// edges
		m_rise = s_r.m_s2 & ~s_r.m_p;
		b_rise = s_r.b_s2 & ~s_r.b_p;
		l_fall = ~s_r.l_s2 & s_r.l_p;
		// frame measurement, new frame at lrclk fall
		fsv = fs_class(s_r.per);
		mcv = mclk_class(s_r.mcnt);
		bcv = bclk_class(s_r.bcnt);
		if (l_fall) begin
			s_nxt.frame_ok = !fsv[3] && !mcv[3] && !bcv[2] &&
				mcv[2:0] >= MCLK_MIN_CODE[fsv[2:0]] &&
				(fsv[2:0] != FS_HI || s_r.regm);
			if (s_nxt.frame_ok) begin
				s_nxt.fsc = fsv[2:0];
				s_nxt.mcode = mcv[2:0];
			end
			s_nxt.per = '0;
			s_nxt.mcnt = '0;
			s_nxt.bcnt = '0;
		end else begin
			// saturating counts within the frame
			if (s_r.per != '1) s_nxt.per = s_r.per + 12'h1;
			if (m_rise && s_r.mcnt != '1) begin
				s_nxt.mcnt = s_r.mcnt + 10'h1;
			end
			if (b_rise && s_r.bcnt != '1) begin
				s_nxt.bcnt = s_r.bcnt + 7'h1;
			end
		end
		// idle watch on the fast clocks
		s_nxt.m_idle = m_rise ? 8'h00 :
			(s_r.m_idle == CLK_STOP_CYC ? s_r.m_idle : s_r.m_idle + 8'h01);
		s_nxt.b_idle = b_rise ? 8'h00 :
			(s_r.b_idle == CLK_STOP_CYC ? s_r.b_idle : s_r.b_idle + 8'h01);
		// a stopped clock or shutdown ends the good run
		if (s_r.per >= LR_STOP_CYC || s_r.m_idle == CLK_STOP_CYC ||
			s_r.b_idle == CLK_STOP_CYC || s_r.state == ST_SHUT) begin
			s_nxt.frame_ok = 1'b0;
		end
		clk_bad = !s_r.frame_ok;
		// I2S receive: MSB one slot after frame edge
		if (b_rise) begin
			s_nxt.lr_bit = s_r.l_s2;
			if (s_r.l_s2 != s_r.lr_bit) begin
				s_nxt.bit_idx = '0;
				if (s_r.lr_bit) begin
					s_nxt.samp_r = s_r.shreg;
				end else begin
					s_nxt.samp_l = s_r.shreg;
				end
			end else if (s_r.bit_idx != '1) begin
				s_nxt.bit_idx = s_r.bit_idx + 6'h1;
			end
			if (s_nxt.bit_idx >= 6'h1 && s_nxt.bit_idx <= 6'(WORD_BITS)) begin
				s_nxt.shreg = {s_r.shreg[14:0], s_r.d_s2};
			end
		end
		// PWM period from mclk ratio and held rate select
		pwm_per = 7'(MCLK_RATIO[s_r.mcode] >>
			(s_r.freq ? PWM_SH_HI : PWM_SH_LO));
		wrap = m_rise && ({1'b0, s_r.pwm_cnt} >= pwm_per - 7'h1);
		if (wrap) begin
			s_nxt.pwm_cnt = '0;
		end else if (m_rise) begin
			s_nxt.pwm_cnt = s_r.pwm_cnt + 6'h1;
		end
		// parallel load plays the right channel on both
		duty_l = to_duty(s_r.pload ? s_r.samp_r : s_r.samp_l,
			pwm_per, s_r.sclip);
		duty_r = to_duty(s_r.samp_r, pwm_per, s_r.sclip);
		// mode sequence
		unique case (s_r.state)
			ST_SHUT: begin
				if (s_r.sd_s2) begin
					// latch straps on release
					s_nxt.freq = s_r.fr_s2;
					s_nxt.pload = s_r.pl_s2;
					s_nxt.sclip = s_r.sc_s2;
					s_nxt.regm = s_r.g_s2 == GAIN_REG_MODE;
					s_nxt.state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				// clocks must prove valid first
				if (!clk_bad) begin
					s_nxt.state = s_r.sl_s2 ? ST_SLEEP : ST_PLAY;
				end
			end
			ST_PLAY: begin
				if (clk_bad) begin
					s_nxt.state = ST_WAIT;
				end else if (s_r.sl_s2 && wrap) begin
					s_nxt.state = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (clk_bad) begin
					s_nxt.state = ST_WAIT;
				end else if (!s_r.sl_s2) begin
					s_nxt.state = ST_PLAY;
				end
			end
		endcase
		// shutdown overrides everything
		if (!s_r.sd_s2) s_nxt.state = ST_SHUT;
		// output stage switches only while playing
		s_nxt.out_en = s_nxt.state == ST_PLAY;
		s_nxt.pwm_l = s_nxt.out_en && ({1'b0, s_r.pwm_cnt} < duty_l);
		s_nxt.pwm_r = s_nxt.out_en && ({1'b0, s_r.pwm_cnt} < duty_r);
		// fault low while waiting for valid clocks
		s_nxt.fault = s_nxt.state == ST_WAIT;
		// headphone mute
		s_nxt.hp_mute = !s_r.su_s2 || s_r.mq_s2 || s_nxt.state == ST_SHUT;
	end
	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_r <= '0;
			s_r.hp_mute <= 1'b1; // muted from reset
		end else begin
			s_r <= s_nxt;
		end
	end
	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign pins.amp_fault_n_o = 1'b0; // open drain pulls low only
	assign pins.amp_fault_n_oe = s_r.fault;
	assign pwm_l = s_r.pwm_l;
	assign pwm_r = s_r.pwm_r;
	assign pwm_en = s_r.out_en;
	assign hp_mute = s_r.hp_mute;
	assign clk_err = s_r.fault;
	assign reg_mode = s_r.regm;
	assign fs_code = s_r.fsc;
endmodule : psapc_amp
`default_nettype wire

// ===== core/psapc_host.sv
// Purpose: host end, drives I2S clocks, data and control pins
// Assumes: software port with one-cycle strobes
// Notes: clocks made by dividers from clk_sys
`timescale 1ns/1ps
`default_nettype none
module psapc_host
	import psapc_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// software port
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// interrupt
	output logic irq,
	// pins to the amp
	psapc_if.host pins
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] ctrl, mdiv, bdiv; // control and dividers
		logic [1:0] bsel; // bclk ratio select
		logic [15:0] left, right; // words to send
		logic [2:0] ist, imask; // sticky events, mask
		logic [31:0] rdata;
		logic [7:0] mdcnt, bdcnt; // divider counts
		logic mclk, bclk, lrclk, sdata;
		logic [5:0] bitcnt; // slot within half frame
		logic [15:0] shreg;
		logic f_s1, f_s2, f_p; // fault sync and previous
		logic sd_out; // shutdown pin level
		logic [7:0] lead; // sleep lead count
	} psapc_host_t;
	psapc_host_t s_r, s_nxt;
	logic [2:0] ev; // events this cycle
	logic [5:0] half; // bits per half frame
	logic run;
	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		ev = '0;
		s_nxt.rdata = '0;
		run = s_r.ctrl[C_RUN];
		// only 32, 48 or 64 slots per frame
		half = 6'(BCLK_RATIO[s_r.bsel == 2'h3 ? 2'h2 : s_r.bsel] / 2);
		// fault line sync
		s_nxt.f_s1 = pins.amp_fault_n;
		s_nxt.f_s2 = s_r.f_s1;
		s_nxt.f_p = s_r.f_s2;
		ev[IRQ_FFALL] = s_r.f_p & ~s_r.f_s2;
		ev[IRQ_FRISE] = ~s_r.f_p & s_r.f_s2;
		// clock generation
		if (!run) begin
			s_nxt.mclk = 1'b0;
			s_nxt.bclk = 1'b0;
			// frame and data hold; they move only on a bclk fall
			s_nxt.mdcnt = '0;
			s_nxt.bdcnt = '0;
			s_nxt.bitcnt = '0;
		end else begin
			if (s_r.mdcnt >= s_r.mdiv - 8'h1) begin
				s_nxt.mdcnt = '0;
				s_nxt.mclk = ~s_r.mclk;
			end else begin
				s_nxt.mdcnt = s_r.mdcnt + 8'h1;
			end
			if (s_r.bdcnt >= s_r.bdiv - 8'h1) begin
				s_nxt.bdcnt = '0;
				s_nxt.bclk = ~s_r.bclk;
				// I2S data moves on the falling bclk
				if (s_r.bclk) begin
					if (s_r.bitcnt >= half - 6'h1) begin
						s_nxt.bitcnt = '0;
						s_nxt.lrclk = ~s_r.lrclk;
						s_nxt.shreg = s_r.lrclk ? s_r.left : s_r.right;
						s_nxt.sdata = 1'b0;
						ev[IRQ_FRAME] = s_r.lrclk;
					end else begin
						s_nxt.bitcnt = s_r.bitcnt + 6'h1;
						s_nxt.sdata = s_r.shreg[15];
						s_nxt.shreg = {s_r.shreg[14:0], 1'b0};
					end
				end
			end else begin
				s_nxt.bdcnt = s_r.bdcnt + 8'h1;
			end
		end
		// sleep first, shutdown after the lead
		if (s_r.ctrl[C_SDN]) begin
			s_nxt.sd_out = 1'b1;
			s_nxt.lead = '0;
		end else if (s_r.sd_out && s_r.lead < SD_LEAD_CYC) begin
			s_nxt.lead = s_r.lead + 8'h1;
		end else begin
			s_nxt.sd_out = 1'b0;
		end
		// register writes
		if (wr) begin
			case (addr)
				A_CTRL: begin
					// straps change only in shutdown
					s_nxt.ctrl = s_r.sd_out ?
						(wdata[7:0] & ~STRAP_MASK) | (s_r.ctrl & STRAP_MASK) :
						wdata[7:0];
				end
				A_MDIV: s_nxt.mdiv = wdata[7:0];
				A_BDIV: s_nxt.bdiv = wdata[7:0];
				A_BSEL: s_nxt.bsel = wdata[1:0];
				A_LEFT: s_nxt.left = wdata[15:0];
				A_RIGHT: s_nxt.right = wdata[15:0];
				A_IMASK: s_nxt.imask = wdata[2:0];
				default: begin
					// other offsets ignored here; an A_IST write clears sticky bits below
				end
			endcase
		end
		// sticky events, set beats write-one clear
		s_nxt.ist = (s_r.ist & ~((wr && addr == A_IST) ?
			wdata[2:0] : 3'h0)) | ev;
		// register reads, data in the next cycle
		if (rd) begin
			case (addr)
				A_CTRL: s_nxt.rdata = {24'h0, s_r.ctrl};
				A_MDIV: s_nxt.rdata = {24'h0, s_r.mdiv};
				A_BDIV: s_nxt.rdata = {24'h0, s_r.bdiv};
				A_BSEL: s_nxt.rdata = {30'h0, s_r.bsel};
				A_LEFT: s_nxt.rdata = {16'h0, s_r.left};
				A_RIGHT: s_nxt.rdata = {16'h0, s_r.right};
				A_STAT: s_nxt.rdata = {29'h0, s_r.sd_out,
					pins.amp_sleep_or_addr_pin, s_r.f_s2};
				A_IST: s_nxt.rdata = {29'h0, s_r.ist};
				A_IMASK: s_nxt.rdata = {29'h0, s_r.imask};
				default: s_nxt.rdata = '0;
			endcase
		end
	end
	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_r <= '0;
			s_r.ctrl <= CTRL_RST;
			s_r.mdiv <= MDIV_RST;
			s_r.bdiv <= BDIV_RST;
			s_r.bsel <= BSEL_RST;
			{s_r.f_s1, s_r.f_s2, s_r.f_p} <= 3'h7; // fault line idles high
		end else begin
			s_r <= s_nxt;
		end
	end
	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign rdata = s_r.rdata;
	assign irq = |(s_r.ist & s_r.imask);
	assign pins.audio_mclk = s_r.mclk;
	assign pins.audio_bclk = s_r.bclk;
	assign pins.audio_lrclk = s_r.lrclk;
	assign pins.audio_sdata = s_r.sdata;
	assign pins.amp_shutdown_n = s_r.sd_out;
	// sleep held high through the shutdown lead
	assign pins.amp_sleep_or_addr_pin = s_r.ctrl[C_SLEEP] |
		~s_r.ctrl[C_SDN];
	assign pins.switch_rate_select_pin = s_r.ctrl[C_FREQ];
	assign pins.parallel_load_select_pin = s_r.ctrl[C_PLOAD];
	assign pins.gain_sel_pin = s_r.ctrl[C_GAIN+1:C_GAIN];
	assign pins.soft_clip_level_pin = s_r.ctrl[C_SCLIP];
endmodule : psapc_host
`default_nettype wire

// ===== test/psapc_properties.sv
// Purpose: pin checks between host and amp ends
// Assumes: sees link pins only
// Notes: placed beside the link, no bind
`timescale 1ns/1ps
`default_nettype none
module psapc_properties
	import psapc_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// link pins
	input wire logic audio_bclk,
	input wire logic audio_lrclk,
	input wire logic audio_sdata,
	input wire logic amp_shutdown_n,
	input wire logic amp_sleep_or_addr_pin,
	input wire logic amp_fault_n_oe
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	logic [8:0] slp_r; // sleep high cycles
	logic [8:0] idl_r; // cycles since bclk moved
	logic [6:0] brc_r; // bclk rises in frame
	logic arm_r; // whole frame under way
	// helper counters; sleep and idle counts saturate
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			slp_r <= 9'h000;
			idl_r <= 9'h000;
			brc_r <= 7'h00;
			arm_r <= 1'b0;
		end else begin
			slp_r <= amp_sleep_or_addr_pin ? slp_r + 9'(slp_r < 9'h1FF) : 9'h000;
			idl_r <= $changed(audio_bclk) ? 9'h000 : idl_r + 9'(idl_r < 9'h1FF);
			brc_r <= $fell(audio_lrclk) ? 7'h00 : brc_r + 7'($rose(audio_bclk));
			arm_r <= idl_r < 9'h028 && (arm_r || $fell(audio_lrclk));
		end
	end
	a_sleep_lead: assert property ($fell(amp_shutdown_n) |->
		slp_r >= 9'(SD_LEAD_CYC) - 9'h002) else $error("short sleep lead");
	a_shut_frees_fault: assert property ($fell(amp_shutdown_n) |->
		##[1:8] !amp_fault_n_oe) else $error("fault held in shutdown");
	a_shut_quiet: assert property (!amp_shutdown_n &&
		$past(!amp_shutdown_n, 8) |-> !amp_fault_n_oe) else $error("fault in shut");
	a_release_waits: assert property ($rose(amp_shutdown_n) |->
		##[1:8] amp_fault_n_oe) else $error("no fault before frames");
	a_stop_faults: assert property (amp_shutdown_n &&
		$past(amp_shutdown_n, 8) && idl_r > 9'h120 |-> amp_fault_n_oe)
		else $error("stop not flagged");
	a_data_on_fall: assert property ($changed(audio_sdata) |->
		$fell(audio_bclk)) else $error("data off bclk fall");
	a_frame_on_fall: assert property ($changed(audio_lrclk) |->
		$fell(audio_bclk)) else $error("frame off bclk fall");
	a_slot_count: assert property ($fell(audio_lrclk) && arm_r |->
		brc_r inside {7'h20, 7'h30, 7'h40}) else $error("bad slot count");
	c_frame: cover property ($fell(audio_lrclk) && arm_r);
	c_stop: cover property (amp_shutdown_n && idl_r == 9'h130);
	c_shut: cover property ($fell(amp_shutdown_n));
endmodule : psapc_properties
`default_nettype wire

// ===== test/tb_top.sv
// Purpose: host and amp ends run against each other
// Assumes: clk_sys 40 ns, reset 16 cycles
// Notes: rate verdicts come from ok_rate
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import psapc_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic supply_ok = 1'b1;
	logic mute_req = 1'b0; // headphone mute request pin
	logic [31:0] rdata;
	logic irq, pwm_l, pwm_r, pwm_en, hp_mute, clk_err, reg_mode;
	logic [2:0] fs_code;
	int error_cnt = 0;
	int comparisons = 0;
	int cyc = 0;
	logic [31:0] seed = 32'h62; // xorshift state
	int tm[11] = '{2, 1, 3, 4, 2, 2, 4, 4, 2, 1, 2}; // mclk halves
	int td[11] = '{4, 4, 8, 8, 8, 12, 12, 16, 16, 8, 8}; // bclk halves
	int ts[11] = '{2, 0, 2, 2, 2, 2, 2, 2, 2, 1, 0}; // slot codes
	psapc_if link();
	psapc_host u_psapc_host(.clk_sys(clk_sys), .rst(rst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
		.pins(link));
	psapc_amp u_psapc_amp(.clk_sys(clk_sys), .rst(rst), .pins(link),
		.supply_ok(supply_ok), .hp_mute_req(mute_req), .pwm_l(pwm_l),
		.pwm_r(pwm_r), .pwm_en(pwm_en), .hp_mute(hp_mute), .clk_err(clk_err),
		.reg_mode(reg_mode), .fs_code(fs_code));
	psapc_properties u_psapc_properties(.clk_sys(clk_sys), .rst(rst),
		.audio_bclk(link.audio_bclk), .audio_lrclk(link.audio_lrclk),
		.audio_sdata(link.audio_sdata), .amp_shutdown_n(link.amp_shutdown_n),
		.amp_sleep_or_addr_pin(link.amp_sleep_or_addr_pin),
		.amp_fault_n_oe(link.amp_fault_n_oe));
	initial begin
		forever #20 clk_sys = ~clk_sys;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	// legal frame: 12..48 kHz, listed ratio, low rates need more
	function automatic logic ok_rate(input int m, input int b, input int s);
		int fr;
		int r;
		int mn;
		fr = s * b * 2;
		r = (s * b % m == 0) ? s * b / m : 0;
		mn = fr > 1786 ? 512 : fr > 1250 ? 256 : fr > 892 ? 192 : 128;
		return fr >= 500 && fr <= 2500 && r >= mn &&
			r inside {128, 192, 256, 384, 512};
	endfunction : ok_rate
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
		@(posedge clk_sys);
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		@(posedge clk_sys);
		v = rdata;
	endtask : rd_reg
	// sleep with clocks running, then stop clocks and shut down
	task automatic shut();
		wr_reg(A_CTRL, 32'h80);
		repeat (200) @(posedge clk_sys);
		chk("pwm_en", 32'h0, 32'(pwm_en));
		chk("pwm_r", 32'h0, 32'(pwm_r));
		wr_reg(A_CTRL, 32'h0);
		repeat (80) @(posedge clk_sys);
		chk("mute", 32'h1, 32'(hp_mute));
	endtask : shut
	task automatic period(output int p);
		realtime t;
		@(posedge pwm_l);
		t = $realtime;
		@(posedge pwm_l);
		p = int'(($realtime - t) / 40.0);
	endtask : period
	task automatic give_verdict();
		$display("errors %0d of %0d checks", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : give_verdict
	// hang guard
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			error_cnt++;
			give_verdict();
		end
	end
	initial begin
		logic [31:0] v;
		int p;
		int s;
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		rd_reg(A_MDIV, v);
		chk("mdiv", 32'(MDIV_RST), v);
		rd_reg(A_IST, v);
		chk("ist", 32'h0, v);
		seed = xs(seed);
		wr_reg(8'h24, seed);
		rd_reg(8'h24, v);
		chk("unmapped", 32'h0, v);
		wr_reg(A_RIGHT, seed);
		rd_reg(A_RIGHT, v);
		chk("right", {16'h0, seed[15:0]}, v);
		for (int i = 0; i < 11; i++) begin
			s = ts[i] == 0 ? 32 : ts[i] == 1 ? 48 : 64;
			shut();
			wr_reg(A_MDIV, 32'(tm[i]));
			wr_reg(A_BDIV, 32'(td[i]));
			wr_reg(A_BSEL, 32'(ts[i]));
			wr_reg(A_CTRL, 32'h81);
			v = 32'(ok_rate(tm[i], td[i], s));
			// let the amp leave shutdown and pull fault first
			repeat (8) @(posedge clk_sys);
			for (int k = 0; k < 6 * s * td[i] + 400; k++) begin
				if (link.amp_fault_n === 1'b1) break;
				@(posedge clk_sys);
			end
			repeat (4) @(posedge clk_sys);
			chk("fault", v, 32'(link.amp_fault_n));
			chk("pwm_en", v, 32'(pwm_en));
			chk("clk_err", 32'(!v[0]), 32'(clk_err));
		end
		period(p);
		chk("period", 32'(s * td[10] * 2 / 16), 32'(p));
		wr_reg(A_CTRL, 32'hFD);
		rd_reg(A_CTRL, v);
		chk("ctrl", 32'h81, v);
		shut();
		wr_reg(A_CTRL, 32'hB5);
		repeat (2000) @(posedge clk_sys);
		period(p);
		chk("period", 32'(s * td[10] * 2 / 8), 32'(p));
		chk("reg_mode", 32'h1, 32'(reg_mode));
		chk("fs_code", 32'h6, 32'(fs_code));
		mute_req <= 1'b1;
		repeat (6) @(posedge clk_sys);
		chk("mute", 32'h1, 32'(hp_mute));
		mute_req <= 1'b0;
		repeat (6) @(posedge clk_sys);
		chk("mute", 32'h0, 32'(hp_mute));
		supply_ok <= 1'b0;
		repeat (6) @(posedge clk_sys);
		chk("mute", 32'h1, 32'(hp_mute));
		supply_ok <= 1'b1;
		chk("irq", 32'h0, 32'(irq));
		wr_reg(A_IMASK, 32'h1);
		chk("irq", 32'h1, 32'(irq));
		wr_reg(A_CTRL, 32'h35);
		repeat (400) @(posedge clk_sys);
		chk("fault", 32'h0, 32'(link.amp_fault_n));
		rd_reg(A_IST, v);
		chk("ist", 32'h7, v);
		wr_reg(A_IST, 32'h7);
		chk("irq", 32'h0, 32'(irq));
		give_verdict();
	end
endmodule : tb_top
`default_nettype wire
